//--- dual_port_addr_gpio_pkg.sv
// constants shared by the dual address/gpio port block
package dual_port_addr_gpio_pkg;

    // ==========================================================
    // widths
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned MODE_W = 2;

    // ==========================================================
    // register map (byte addresses on the cpu's internal bus)
    localparam logic [ADDR_W-1:0] LOW_PORT_DIRECTION_ADDR = 16'hffb0;
    localparam logic [ADDR_W-1:0] HIGH_PORT_DIRECTION_ADDR = 16'hffb1;
    localparam logic [ADDR_W-1:0] LOW_PORT_DATA_LATCH_ADDR = 16'hffb2;
    localparam logic [ADDR_W-1:0] HIGH_PORT_DATA_LATCH_ADDR = 16'hffb3;

    // ==========================================================
    // reset values and fixed read values
    localparam logic [PORT_W-1:0] DIRECTION_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DATA_LATCH_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DIRECTION_ALL_OUT = 8'hff;
    localparam logic [PORT_W-1:0] DIRECTION_READ_VALUE = 8'hff;
    localparam logic [PORT_W-1:0] UNMAPPED_READ_VALUE = 8'h00;
    localparam logic [PORT_W-1:0] PIN_ALL_LOW = 8'h00;

    // ==========================================================
    // operating mode codes on the mode straps
    localparam logic [MODE_W-1:0] MODE_EXPANDED_NO_ROM = 2'h1;
    localparam logic [MODE_W-1:0] MODE_EXPANDED_ROM = 2'h2;
    localparam logic [MODE_W-1:0] MODE_SINGLE_CHIP = 2'h3;

    // ==========================================================
    // address bus slices carried by each port
    localparam int unsigned LOW_ADDR_LSB = 0;
    localparam int unsigned HIGH_ADDR_LSB = 8;

    typedef enum logic [1:0] {
        PORT_MODE_FORCED_ADDR,
        PORT_MODE_PER_PIN,
        PORT_MODE_GPIO
    } port_mode_t;

endpackage : dual_port_addr_gpio_pkg

//--- dual_port_addr_gpio.sv
// two 8-bit gpio ports that double as the external address bus halves
`timescale 1ns/1ps

// Behaviour
// - low port carries address bits 7..0
// - high port carries address bits 15..8
// - direction bit 1 output, 0 input
// - data read: latch for outputs, pin otherwise
// - direction registers read back all ones
// - modes 2/3: input data bit enables pull-up
// - pull-ups off: outputs, and all in mode 1
// - mode 1: direction forced ones, writes ignored
// - mode 2: direction picks input or address
// - mode 3: plain gpio, no address
// - reset clears direction and data to zero
// - mode 1: direction all ones after reset
// - hardware standby: pins float, pull-ups off
// - software standby: registers keep their contents
// - software standby: address pins driven low
// - software standby: gpio outputs keep latch value
module dual_port_addr_gpio (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [dual_port_addr_gpio_pkg::MODE_W-1:0] mode_pins,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [dual_port_addr_gpio_pkg::ADDR_W-1:0] ext_addr,
    input wire logic [dual_port_addr_gpio_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [dual_port_addr_gpio_pkg::PORT_W-1:0] bus_wdata,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic [dual_port_addr_gpio_pkg::PORT_W-1:0] low_pin_in,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] low_pin_out,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] low_pin_oe_n,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] low_pullup_en,
    input wire logic [dual_port_addr_gpio_pkg::PORT_W-1:0] high_pin_in,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] high_pin_out,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] high_pin_oe_n,
    output logic [dual_port_addr_gpio_pkg::PORT_W-1:0] high_pullup_en
);
    import dual_port_addr_gpio_pkg::*;

    // ==========================================================
    // synchronisers for pins and mode straps
    logic [MODE_W-1:0] mode_meta_q;
    logic [MODE_W-1:0] mode_q;
    logic [PORT_W-1:0] low_pin_meta_q;
    logic [PORT_W-1:0] low_pin_q;
    logic [PORT_W-1:0] high_pin_meta_q;
    logic [PORT_W-1:0] high_pin_q;

    // the first flop of each pair feeds only the second, never the logic
    // straps reset to single-chip so no pin drives address while they settle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_meta_q <= MODE_SINGLE_CHIP;
            mode_q <= MODE_SINGLE_CHIP;
        end else if (clk_en) begin
            mode_meta_q <= mode_pins;
            mode_q <= mode_meta_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_pin_meta_q <= PIN_ALL_LOW;
            low_pin_q <= PIN_ALL_LOW;
        end else if (clk_en) begin
            low_pin_meta_q <= low_pin_in;
            low_pin_q <= low_pin_meta_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_pin_meta_q <= PIN_ALL_LOW;
            high_pin_q <= PIN_ALL_LOW;
        end else if (clk_en) begin
            high_pin_meta_q <= high_pin_in;
            high_pin_q <= high_pin_meta_q;
        end
    end

    // ==========================================================
    // mode decode
    port_mode_t port_mode;
    wire forced_addr;
    wire per_pin_addr;

    // unknown code 0 falls back to single-chip so pins never drive address by accident
    assign port_mode = (mode_q == MODE_EXPANDED_NO_ROM) ? PORT_MODE_FORCED_ADDR :
                       (mode_q == MODE_EXPANDED_ROM) ? PORT_MODE_PER_PIN : PORT_MODE_GPIO;
    assign forced_addr = (port_mode == PORT_MODE_FORCED_ADDR);
    assign per_pin_addr = (port_mode == PORT_MODE_PER_PIN);

    // ==========================================================
    // register decode
    wire wr_low_dir;
    wire wr_high_dir;
    wire wr_low_data;
    wire wr_high_data;
    wire rd_dir;
    wire rd_low_data;
    wire rd_high_data;

    wire wr_allowed;

    // cpu is halted in software standby, so writes are also blocked there
    assign wr_allowed = bus_wr && !sw_standby;
    assign wr_low_dir = wr_allowed && (bus_addr == LOW_PORT_DIRECTION_ADDR);
    assign wr_high_dir = wr_allowed && (bus_addr == HIGH_PORT_DIRECTION_ADDR);
    assign wr_low_data = wr_allowed && (bus_addr == LOW_PORT_DATA_LATCH_ADDR);
    assign wr_high_data = wr_allowed && (bus_addr == HIGH_PORT_DATA_LATCH_ADDR);
    assign rd_dir = (bus_addr == LOW_PORT_DIRECTION_ADDR) ||
                    (bus_addr == HIGH_PORT_DIRECTION_ADDR);
    assign rd_low_data = (bus_addr == LOW_PORT_DATA_LATCH_ADDR);
    assign rd_high_data = (bus_addr == HIGH_PORT_DATA_LATCH_ADDR);

    // ==========================================================
    // direction and data latch registers
    logic [PORT_W-1:0] low_dir_q;
    logic [PORT_W-1:0] low_dir_d;
    logic [PORT_W-1:0] high_dir_q;
    logic [PORT_W-1:0] high_dir_d;
    logic [PORT_W-1:0] low_latch_q;
    logic [PORT_W-1:0] low_latch_d;
    logic [PORT_W-1:0] high_latch_q;
    logic [PORT_W-1:0] high_latch_d;

    // mode 1 overrides any write and sets all ones at the third enabled edge after reset lifts, once the straps clear the sync flops
    assign low_dir_d = forced_addr ? DIRECTION_ALL_OUT :
                       wr_low_dir ? bus_wdata : low_dir_q;
    assign high_dir_d = forced_addr ? DIRECTION_ALL_OUT :
                        wr_high_dir ? bus_wdata : high_dir_q;
    assign low_latch_d = wr_low_data ? bus_wdata : low_latch_q;
    assign high_latch_d = wr_high_data ? bus_wdata : high_latch_q;

    // a write lands at its enabled edge; pins follow one cycle later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_dir_q <= DIRECTION_RESET;
        end else if (clk_en) begin
            low_dir_q <= low_dir_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_dir_q <= DIRECTION_RESET;
        end else if (clk_en) begin
            high_dir_q <= high_dir_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_latch_q <= DATA_LATCH_RESET;
        end else if (clk_en) begin
            low_latch_q <= low_latch_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_latch_q <= DATA_LATCH_RESET;
        end else if (clk_en) begin
            high_latch_q <= high_latch_d;
        end
    end

    // ==========================================================
    // read path
    logic [PORT_W-1:0] rdata_d;
    wire [PORT_W-1:0] low_read_view;
    wire [PORT_W-1:0] high_read_view;

    // input pins bypass the latch; the pin view is the synchronised level
    assign low_read_view = (low_dir_q & low_latch_q) | (~low_dir_q & low_pin_q);
    assign high_read_view = (high_dir_q & high_latch_q) | (~high_dir_q & high_pin_q);
    wire [PORT_W-1:0] data_read_view;

    assign data_read_view = rd_low_data ? low_read_view :
                            rd_high_data ? high_read_view : UNMAPPED_READ_VALUE;
    // the direction contents stay hidden, so software must keep its own copy
    assign rdata_d = rd_dir ? DIRECTION_READ_VALUE : data_read_view;

    // read data holds between reads so a slow master may sample it late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= UNMAPPED_READ_VALUE;
        end else if (clk_en) begin
            bus_rdata <= bus_rd ? rdata_d : bus_rdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rvalid <= 1'b0;
        end else if (clk_en) begin
            bus_rvalid <= bus_rd;
        end
    end

    // ==========================================================
    // pin function per bit
    wire [PORT_W-1:0] low_addr_sel;
    wire [PORT_W-1:0] high_addr_sel;
    wire [PORT_W-1:0] low_addr_bits;
    wire [PORT_W-1:0] high_addr_bits;
    wire [PORT_W-1:0] low_out_d;
    wire [PORT_W-1:0] high_out_d;
    wire [PORT_W-1:0] low_oe_n_d;
    wire [PORT_W-1:0] high_oe_n_d;
    wire [PORT_W-1:0] low_pull_d;
    wire [PORT_W-1:0] high_pull_d;

    assign low_addr_bits = ext_addr[LOW_ADDR_LSB +: PORT_W];
    assign high_addr_bits = ext_addr[HIGH_ADDR_LSB +: PORT_W];

    // mode 1 all address; mode 2 per direction bit; mode 3 never address
    assign low_addr_sel = forced_addr ? DIRECTION_ALL_OUT :
                          per_pin_addr ? low_dir_q : PIN_ALL_LOW;
    assign high_addr_sel = forced_addr ? DIRECTION_ALL_OUT :
                           per_pin_addr ? high_dir_q : PIN_ALL_LOW;

    // address pins go low in software standby, gpio outputs hold the latch
    wire [PORT_W-1:0] low_addr_drive;
    wire [PORT_W-1:0] high_addr_drive;
    wire pin_float;
    wire pull_blocked;

    assign low_addr_drive = sw_standby ? PIN_ALL_LOW : low_addr_bits;
    assign high_addr_drive = sw_standby ? PIN_ALL_LOW : high_addr_bits;
    assign low_out_d = (low_addr_sel & low_addr_drive) |
                       (~low_addr_sel & low_latch_q);
    assign high_out_d = (high_addr_sel & high_addr_drive) |
                        (~high_addr_sel & high_latch_q);

    // direction bit 0 leaves the pin undriven; hardware standby floats all
    // registers are not cleared here, the reset that comes with standby does it
    assign pin_float = hw_standby;
    assign low_oe_n_d = pin_float ? DIRECTION_ALL_OUT : ~low_dir_q;
    assign high_oe_n_d = pin_float ? DIRECTION_ALL_OUT : ~high_dir_q;

    // pull-up only on an input pin whose latch bit is 1, outside mode 1
    assign pull_blocked = hw_standby || forced_addr;
    assign low_pull_d = pull_blocked ? PIN_ALL_LOW :
                        (~low_dir_q & low_latch_q);
    assign high_pull_d = pull_blocked ? PIN_ALL_LOW :
                         (~high_dir_q & high_latch_q);

    // registered pins cost one cycle of address latency but keep glitches off the bus
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_pin_out <= PIN_ALL_LOW;
        end else if (clk_en) begin
            low_pin_out <= low_out_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_pin_out <= PIN_ALL_LOW;
        end else if (clk_en) begin
            high_pin_out <= high_out_d;
        end
    end

    // every pin floats during reset until the direction register says otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_pin_oe_n <= DIRECTION_ALL_OUT;
        end else if (clk_en) begin
            low_pin_oe_n <= low_oe_n_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_pin_oe_n <= DIRECTION_ALL_OUT;
        end else if (clk_en) begin
            high_pin_oe_n <= high_oe_n_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_pullup_en <= PIN_ALL_LOW;
        end else if (clk_en) begin
            low_pullup_en <= low_pull_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_pullup_en <= PIN_ALL_LOW;
        end else if (clk_en) begin
            high_pullup_en <= high_pull_d;
        end
    end

endmodule : dual_port_addr_gpio

//--- dual_port_addr_gpio_sva.sv
// assertion checker for the dual address/gpio port block
`timescale 1ns/1ps
module dual_port_addr_gpio_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [1:0] mode_pins,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic [7:0] low_pin_out,
    input wire logic [7:0] low_pin_oe_n,
    input wire logic [7:0] low_pullup_en,
    input wire logic [7:0] high_pin_out,
    input wire logic [7:0] high_pin_oe_n,
    input wire logic [7:0] high_pullup_en
);
    import dual_port_addr_gpio_pkg::*;
    // ==========================================================
    // checks; mode straps pass two sync flops, hence the long holds
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire m1 = mode_pins == MODE_EXPANDED_NO_ROM;
    wire quiet = clk_en && !hw_standby;
    sequence s_low_wr;
        clk_en && bus_wr && !sw_standby && bus_addr == LOW_PORT_DATA_LATCH_ADDR;
    endsequence
    sequence s_gap_rd;
        !bus_wr ##1 quiet && bus_rd && !bus_wr && bus_addr == LOW_PORT_DATA_LATCH_ADDR;
    endsequence
    a_read_one_cycle: assert property (clk_en && bus_rd |=> bus_rvalid)
        else $error("read not answered one cycle later");
    a_dir_reads_ones: assert property (clk_en && bus_rd && bus_addr[15:1] == 15'h7fd8
        |=> bus_rdata == DIRECTION_READ_VALUE) else $error("direction read not all ones");
    a_hw_float: assert property (hw_standby && clk_en |=>
        (low_pin_oe_n & high_pin_oe_n) == 8'hff && (low_pullup_en | high_pullup_en) == 8'h00)
        else $error("pins not floating in hardware standby");
    a_pullup_outputs: assert property (((low_pullup_en & ~low_pin_oe_n) |
        (high_pullup_en & ~high_pin_oe_n)) == 8'h00) else $error("pull-up on a driven pin");
    a_mode1_no_pullup: assert property ((clk_en && m1)[*4] |->
        (low_pullup_en | high_pullup_en) == 8'h00) else $error("pull-up on in mode 1");
    a_mode1_address: assert property ((quiet && m1 && !sw_standby)[*5] |->
        low_pin_out == $past(ext_addr[7:0]) && high_pin_out == $past(ext_addr[15:8])
        && (low_pin_oe_n | high_pin_oe_n) == 8'h00) else $error("address not driven in mode 1");
    a_swstby_low: assert property ((quiet && m1)[*4] ##1 (quiet && m1 && sw_standby)
        |=> (low_pin_out | high_pin_out) == 8'h00) else $error("address pins not low");
    a_latch_read: assert property (s_low_wr ##1 s_gap_rd |=>
        ((bus_rdata ^ $past(bus_wdata, 3)) & ~low_pin_oe_n) == 8'h00)
        else $error("output pin read does not return latch");
endmodule : dual_port_addr_gpio_sva
bind dual_port_addr_gpio dual_port_addr_gpio_sva sva_i (.*);

//--- port_far_side.sv
// far-side model of one port: memory or peripheral on the shared pins
`timescale 1ns/1ps
module port_far_side (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] drv,
    output logic [7:0] pin
);
    // the far side yields wherever the port drives, so no bit sees contention
    assign pin = (pin_out & ~pin_oe_n) | (drv & pin_oe_n);
endmodule : port_far_side

//--- dual_port_addr_gpio_tb.sv
// self-checking bench for the dual address/gpio port block
`timescale 1ns/1ps
module dual_port_addr_gpio_tb;
    import dual_port_addr_gpio_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, hw_standby = 1'b0, sw_standby = 1'b0;
    logic bus_wr = 1'b0, bus_rd = 1'b0, bus_rvalid;
    logic [1:0] mode_pins = 2'h3;
    logic [15:0] ext_addr = 16'h0000, bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, low_pin_in, low_pin_out, low_pin_oe_n;
    logic [7:0] low_pullup_en, high_pin_in, high_pin_out, high_pin_oe_n, high_pullup_en;
    int errors = 0, total_checks = 0;
    // ==========================================================
    // harness
    always #2.5 clk = ~clk;
    dual_port_addr_gpio dut (.*);
    port_far_side low_side (.pin_out(low_pin_out), .pin_oe_n(low_pin_oe_n), .drv(8'h3c),
        .pin(low_pin_in));
    port_far_side high_side (.pin_out(high_pin_out), .pin_oe_n(high_pin_oe_n), .drv(8'hc3),
        .pin(high_pin_in));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk({bus_rvalid, bus_rdata}, {1'b1, e});
    endtask : rd
    // driven bits only: a floating pin's drive value means nothing
    task automatic pins(input logic [23:0] lo, input logic [23:0] hi);
        chk({low_pin_out & ~low_pin_oe_n, low_pin_oe_n, low_pullup_en}, lo);
        chk({high_pin_out & ~high_pin_oe_n, high_pin_oe_n, high_pullup_en}, hi);
    endtask : pins
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    // ==========================================================
    // sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        idle(1);
        pins(24'h00ff00, 24'h00ff00);
        rd(LOW_PORT_DIRECTION_ADDR, 8'hff);
        rd(LOW_PORT_DATA_LATCH_ADDR, 8'h3c);
        rd(16'hffb4, UNMAPPED_READ_VALUE);
        wr(LOW_PORT_DIRECTION_ADDR, 8'h0f);
        wr(LOW_PORT_DATA_LATCH_ADDR, 8'ha5);
        rd(LOW_PORT_DATA_LATCH_ADDR, 8'h35);
        pins(24'h05f0a0, 24'h00ff00);
        @(posedge clk);
        sw_standby <= 1'b1;
        wr(LOW_PORT_DATA_LATCH_ADDR, 8'h00);
        wr(LOW_PORT_DIRECTION_ADDR, 8'hff);
        idle(2);
        pins(24'h05f0a0, 24'h00ff00);
        @(posedge clk);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        idle(2);
        pins(24'h00ff00, 24'h00ff00);
        @(posedge clk);
        hw_standby <= 1'b0;
        mode_pins <= 2'h2;
        ext_addr <= 16'h1234;
        wr(HIGH_PORT_DIRECTION_ADDR, 8'hf0);
        wr(HIGH_PORT_DATA_LATCH_ADDR, 8'hff);
        idle(3);
        pins(24'h04f0a0, 24'h100f0f);
        @(posedge clk);
        mode_pins <= 2'h1;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        ext_addr <= 16'habcd;
        idle(5);
        pins(24'hcd0000, 24'hab0000);
        wr(LOW_PORT_DIRECTION_ADDR, 8'h00);
        rd(LOW_PORT_DIRECTION_ADDR, 8'hff);
        pins(24'hcd0000, 24'hab0000);
        @(posedge clk);
        clk_en <= 1'b0;
        ext_addr <= 16'h5a5a;
        idle(3);
        pins(24'hcd0000, 24'hab0000);
        @(posedge clk);
        clk_en <= 1'b1;
        idle(2);
        pins(24'h5a0000, 24'h5a0000);
        @(posedge clk);
        sw_standby <= 1'b1;
        idle(2);
        pins(24'h000000, 24'h000000);
        end_of_test();
    end
endmodule : dual_port_addr_gpio_tb
